// ===== bench/qpe_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module qpe_far_model (
	input  wire logic pclk,
	input  wire logic go,
	input  wire logic cw,
	output var  logic pa,
	output var  logic pb
);
	logic [1:0] s = 2'h0;
	// Gray walk: A leads B clockwise
	always @(posedge pclk) begin
		if (go)
			s <= cw ? s + 2'h1 : s - 2'h1;
	end
	assign pa = s[1] ^ s[0];
	assign pb = s[1];
endmodule
`default_nettype wire

// ===== bench/qpe_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module qpe_top_sva (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        irq,
	input wire logic [3:0]  sink_out,
	input wire logic [3:0]  sink_oe
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence done_s;
		psel && penable && pready && pwrite;
	endsequence
	sequence outs_s;
		done_s ##0 paddr[7:0] == 8'h24;
	endsequence
	wait_state_a: assert property (psel && penable && !pready |=> pready)
		else $error("late ready");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("lone error");
	err_zero_a: assert property (pslverr |-> prdata == 32'h0)
		else $error("data on error");
	sink_float_a: assert property (sink_out == 4'h0)
		else $error("sink level");
	sink_write_a: assert property (outs_s |=> sink_oe == $past(pwdata[3:0]))
		else $error("sink not set");
	sink_hold_a: assert property (!$stable(sink_oe) |-> $past(psel && penable && pready))
		else $error("sink moved");
	irq_clear_a: assert property ($fell(irq) |-> $past(pready && pwrite) || $past(pwrite, 2))
		else $error("irq dropped");
endmodule
bind qpe_top qpe_top_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .irq, .sink_out, .sink_oe);
`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        pready, pslverr, irq, rerr, go = 1'b0, cw = 1'b0, pa, pb, idx = 1'b0;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rdat;
	logic [2:0]  hall = 3'h0;
	logic [3:0]  din = 4'hf, sink_out, sink_oe;
	int          errors = 0, samples_checked = 0, cyc = 0;
	always #5 pclk = ~pclk;
	qpe_far_model u_far (.pclk, .go, .cw, .pa, .pb);
	// Pull-up on each sink pin
	qpe_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .irq, .quad_phase_first(pa), .quad_phase_second(pb),
		.quad_index(idx), .hall, .din, .sink_in(~sink_oe), .sink_out, .sink_oe);
	task automatic give_verdict();
		if (errors == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic cmp(input string n, input logic [32:0] e, input logic [32:0] g);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	// Flop outputs read at the edge still hold their pre-edge value
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {24'h0, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		cmp($sformatf("reg%h", a), {a > 8'h28, e}, {rerr, rdat});
	endtask
	task automatic step(input logic c, input int n);
		repeat (n) begin
			@(posedge pclk);
			go <= 1'b1;
			cw <= c;
			idx <= ~idx;
			@(posedge pclk);
			go <= 1'b0;
			repeat (6) @(posedge pclk);
		end
	endtask
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		step(1'b1, 8);
		chk(8'h04, 32'h8);
		chk(8'h08, 32'h0);
		step(1'b0, 3);
		chk(8'h04, 32'h5);
		xfer(1'b1, 8'h00, 32'h1);
		step(1'b1, 2);
		chk(8'h04, 32'h3);
		xfer(1'b1, 8'h04, 32'hffffffff);
		xfer(1'b1, 8'h08, 32'h0);
		step(1'b0, 1);
		chk(8'h04, 32'h0);
		chk(8'h08, 32'h1);
		xfer(1'b1, 8'h18, 32'h1f);
		xfer(1'b1, 8'h1c, 32'h10);
		xfer(1'b1, 8'h0c, 32'h2);
		xfer(1'b1, 8'h10, 32'h1);
		step(1'b0, 2);
		@(negedge pclk);
		cmp("irq", 33'h1, {32'h0, irq});
		chk(8'h18, 32'h10);
		xfer(1'b1, 8'h18, 32'h10);
		repeat (2) @(negedge pclk);
		cmp("irq", 33'h0, {32'h0, irq});
		xfer(1'b1, 8'h14, 32'he4);
		xfer(1'b1, 8'h1c, 32'h0f);
		din <= 4'h0;
		repeat (8) @(posedge pclk);
		chk(8'h18, 32'h0c);
		xfer(1'b1, 8'h18, 32'h0f);
		din <= 4'hf;
		repeat (8) @(posedge pclk);
		chk(8'h18, 32'h0a);
		xfer(1'b0, 8'h20, 32'h0);
		cmp("pins", 33'hf, {29'h0, rdat[5:2]});
		xfer(1'b1, 8'h18, 32'h0f);
		din <= 4'hb;
		@(posedge pclk);
		din <= 4'hf;
		repeat (8) @(posedge pclk);
		chk(8'h18, 32'h04);
		hall <= 3'h3;
		xfer(1'b1, 8'h00, 32'h4);
		chk(8'h28, 32'h1);
		xfer(1'b1, 8'h00, 32'h6);
		chk(8'h28, 32'h0);
		xfer(1'b1, 8'h24, 32'h5);
		chk(8'h24, 32'ha5);
		chk(8'h3c, 32'h0);
		give_verdict();
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			errors++;
			give_verdict();
		end
	end
endmodule
`default_nettype wire

// ===== verilog/qpe_consts.svh
`ifndef QPE_CONSTS_SVH
`define QPE_CONSTS_SVH

// Register byte offsets (low eight address bits)
`define QPE_A_CTRL   8'h00
`define QPE_A_POS_LO 8'h04
`define QPE_A_POS_HI 8'h08
`define QPE_A_TGT_LO 8'h0c
`define QPE_A_TGT_HI 8'h10
`define QPE_A_EDGE   8'h14
`define QPE_A_STAT   8'h18
`define QPE_A_MASK   8'h1c
`define QPE_A_PINS   8'h20
`define QPE_A_OUTS   8'h24
`define QPE_A_PHASE  8'h28

// Field positions
`define QPE_CTRL_SWAP   0
`define QPE_CTRL_HALL60 1
`define QPE_CTRL_INIT   2
`define QPE_STAT_POS    4

// Reset values
`define QPE_RST_EDGE  8'h00
`define QPE_RST_MASK  5'h00
`define QPE_RST_SINK  4'h0
`define QPE_PHASE_NONE 3'h7

// Synchroniser depth
`define QPE_SYNC_STAGES 2

`endif

// ===== verilog/qpe_pkg.sv
package qpe_pkg;

	typedef enum logic [1:0] {
		QPE_EDGE_NONE,
		QPE_EDGE_RISE,
		QPE_EDGE_FALL,
		QPE_EDGE_BOTH
	} qpe_edge_t;

	typedef struct packed {
		logic [63:0] pos;
		logic [63:0] tgt;
		logic [31:0] pos_hi_snap;
		logic        swap;
		logic        hall60;
		logic [2:0]  phase;
		logic [7:0]  edge_cfg;
		logic [4:0]  stat;
		logic [4:0]  mask;
		logic [3:0]  sink;
		logic [1:0]  ab_prev;
		logic [3:0]  din_prev;
		logic        hit_prev;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        irq;
	} qpe_state_t;

endpackage

// ===== verilog/qpe_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "qpe_consts.svh"

module qpe_sync #(
	parameter int W = 1
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} qpe_sync_st_t;

	qpe_sync_st_t s;
	qpe_sync_st_t next_s;

	// First stage feeds only the second
	always_comb begin
		next_s.s1 = d;
		next_s.s2 = s.s1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign q = s.s2;

endmodule

`default_nettype wire

// ===== verilog/qpe_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "qpe_consts.svh"

module qpe_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	output var  logic        irq,
	input  wire logic        quad_phase_first,
	input  wire logic        quad_phase_second,
	input  wire logic        quad_index,
	input  wire logic [2:0]  hall,
	input  wire logic [3:0]  din,
	input  wire logic [3:0]  sink_in,
	output var  logic [3:0]  sink_out,
	output var  logic [3:0]  sink_oe
);

	qpe_pkg::qpe_state_t s;
	qpe_pkg::qpe_state_t next_s;

	logic [9:0] raw;
	logic [9:0] syn;
	logic       syn_a;
	logic       syn_b;
	logic       syn_idx;
	logic [2:0] syn_hall;
	logic [3:0] syn_din;

	assign raw = {quad_index, hall, din, quad_phase_second, quad_phase_first};

	qpe_sync #(
		.W(10)
	) u_sync (
		.pclk   (pclk),
		.presetn(presetn),
		.d      (raw),
		.q      (syn)
	);

	assign syn_a    = syn[0];
	assign syn_b    = syn[1];
	assign syn_din  = syn[5:2];
	assign syn_hall = syn[8:6];
	assign syn_idx  = syn[9];

	function automatic logic reg_ok(input logic [7:0] a);
		unique case (a)
			`QPE_A_CTRL, `QPE_A_POS_LO, `QPE_A_POS_HI, `QPE_A_TGT_LO,
			`QPE_A_TGT_HI, `QPE_A_EDGE, `QPE_A_STAT, `QPE_A_MASK,
			`QPE_A_PINS, `QPE_A_OUTS, `QPE_A_PHASE: reg_ok = 1'b1;
			default: reg_ok = 1'b0;
		endcase
	endfunction

	// None, rise, fall or both per input; every selected edge counts, bounce included
	function automatic logic edge_hit(
		input logic [1:0] cfg,
		input logic       rise,
		input logic       fall
	);
		qpe_pkg::qpe_edge_t m;
		m = qpe_pkg::qpe_edge_t'(cfg);
		unique case (m)
			qpe_pkg::QPE_EDGE_NONE: edge_hit = 1'b0;
			qpe_pkg::QPE_EDGE_RISE: edge_hit = rise;
			qpe_pkg::QPE_EDGE_FALL: edge_hit = fall;
			qpe_pkg::QPE_EDGE_BOTH: edge_hit = rise | fall;
		endcase
	endfunction

	// Hall code to sector; 60 degree sets invert the middle cell
	function automatic logic [2:0] hall_sector(
		input logic [2:0] h,
		input logic       sp60
	);
		logic [2:0] c;
		c = sp60 ? (h ^ 3'h2) : h;
		unique case (c)
			3'h1: hall_sector = 3'h0;
			3'h3: hall_sector = 3'h1;
			3'h2: hall_sector = 3'h2;
			3'h6: hall_sector = 3'h3;
			3'h4: hall_sector = 3'h4;
			3'h5: hall_sector = 3'h5;
			default: hall_sector = `QPE_PHASE_NONE;
		endcase
	endfunction

	logic [1:0]  ab;
	logic [1:0]  chg;
	logic [3:0]  rise;
	logic [3:0]  fall;
	logic [4:0]  ev;
	logic [4:0]  w1c;
	logic        acc;
	logic        wr;
	logic [7:0]  a8;
	logic [31:0] rd;

	always_comb begin
		next_s = s;
		a8     = paddr[7:0];
		acc    = psel & penable;
		wr     = acc & s.pready & pwrite & reg_ok(a8);
		w1c    = 5'h00;

		// Swap lets an opposite-ordered encoder count correctly
		ab  = s.swap ? {syn_a, syn_b} : {syn_b, syn_a};
		chg = ab ^ s.ab_prev;
		next_s.ab_prev = ab;
		// Single-phase change only; both at once is a glitch and is dropped
		if (chg == 2'b01 || chg == 2'b10) begin
			// Up when new A differs from old B: A leads B is clockwise
			if (ab[0] ^ s.ab_prev[1]) begin
				next_s.pos = s.pos + 64'h1;
			end else begin
				next_s.pos = s.pos - 64'h1;
			end
		end

		// Pin level taken as is: pads pull open inputs high
		rise = syn_din & ~s.din_prev;
		fall = ~syn_din & s.din_prev;
		next_s.din_prev = syn_din;
		for (int i = 0; i < 4; i++) begin
			ev[i] = edge_hit(s.edge_cfg[2*i +: 2], rise[i], fall[i]);
		end

		next_s.hit_prev = (s.pos == s.tgt);
		ev[`QPE_STAT_POS] = (s.pos == s.tgt) & ~s.hit_prev;

		if (wr) begin
			unique case (a8)
				`QPE_A_CTRL: begin
					next_s.swap   = pwdata[`QPE_CTRL_SWAP];
					next_s.hall60 = pwdata[`QPE_CTRL_HALL60];
					if (pwdata[`QPE_CTRL_INIT]) begin
						next_s.phase = hall_sector(syn_hall, pwdata[`QPE_CTRL_HALL60]);
					end
				end
				// Software preset of a word beats a same-cycle encoder step in that word; the other word keeps the step
				`QPE_A_POS_LO: next_s.pos[31:0]  = pwdata;
				`QPE_A_POS_HI: next_s.pos[63:32] = pwdata;
				`QPE_A_TGT_LO: next_s.tgt[31:0]  = pwdata;
				`QPE_A_TGT_HI: next_s.tgt[63:32] = pwdata;
				`QPE_A_EDGE:   next_s.edge_cfg   = pwdata[7:0];
				`QPE_A_STAT:   w1c               = pwdata[4:0];
				`QPE_A_MASK:   next_s.mask       = pwdata[4:0];
				`QPE_A_OUTS:   next_s.sink       = pwdata[3:0];
				default: ;
			endcase
		end

		// New event wins over a same-cycle clear
		next_s.stat = (s.stat & ~w1c) | ev;
		next_s.irq  = |(next_s.stat & next_s.mask);

		rd = 32'h0;
		unique case (a8)
			`QPE_A_CTRL:   rd = {29'h0, 1'b0, s.hall60, s.swap};
			`QPE_A_POS_LO: rd = s.pos[31:0];
			`QPE_A_POS_HI: rd = s.pos_hi_snap;
			`QPE_A_TGT_LO: rd = s.tgt[31:0];
			`QPE_A_TGT_HI: rd = s.tgt[63:32];
			`QPE_A_EDGE:   rd = {24'h0, s.edge_cfg};
			`QPE_A_STAT:   rd = {27'h0, s.stat};
			`QPE_A_MASK:   rd = {27'h0, s.mask};
			// Index is visible here only; counting never looks at it
			`QPE_A_PINS:   rd = {22'h0, syn_idx, syn_hall, syn_din, ab};
			`QPE_A_OUTS:   rd = {24'h0, sink_in, s.sink};
			`QPE_A_PHASE:  rd = {29'h0, s.phase};
			default:       rd = 32'h0;
		endcase

		// One wait state: answer comes on the second access edge
		if (acc && !s.pready) begin
			next_s.pready  = 1'b1;
			next_s.pslverr = ~reg_ok(a8);
			next_s.prdata  = rd;
			// Low word read freezes the high word for a torn-free pair
			if (!pwrite && a8 == `QPE_A_POS_LO) begin
				next_s.pos_hi_snap = s.pos[63:32];
			end
		end else begin
			next_s.pready  = 1'b0;
			next_s.pslverr = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s          <= '0;
			s.edge_cfg <= `QPE_RST_EDGE;
			s.mask     <= `QPE_RST_MASK;
			s.sink     <= `QPE_RST_SINK;
			s.phase    <= `QPE_PHASE_NONE;
		end else begin
			s <= next_s;
		end
	end

	assign prdata   = s.prdata;
	assign pready   = s.pready;
	assign pslverr  = s.pslverr;
	assign irq      = s.irq;
	// Open collector: low level driven only while asserted, else floats
	assign sink_out = 4'h0;
	assign sink_oe  = s.sink;

endmodule

`default_nettype wire
